// ---- design/fwdc_pkg.sv ----
// Purpose: Shared constants and types for the forwarding and clock configuration bank.
// Assumes: APB with 32-bit data; each register sits in the low byte of one aligned word.
// Notes: Register indices are multiplied by four to give the byte address.
package fwdc_pkg;

    localparam int ADDR_W = 8;
    localparam int IDX_W = 6;
    localparam int NUM_PORTS = 4;
    localparam int PORT_IDX_W = 2;
    localparam int FRAME_W = 16;

    // Register indices; byte address is index times four.
    localparam logic [IDX_W-1:0] IDX_FRAME_LIMIT_HIGH = 6'h1d;
    localparam logic [IDX_W-1:0] IDX_MAX_FRAME_COUNT_LOW = 6'h1e;
    localparam logic [IDX_W-1:0] IDX_CSI_PLL_CLOCK_CONTROL = 6'h1f;
    localparam logic [IDX_W-1:0] IDX_PORT_FORWARD_DISABLE = 6'h20;
    localparam logic [IDX_W-1:0] IDX_FORWARD_MODE_CONTROL = 6'h21;
    localparam logic [IDX_W-1:0] IDX_FORWARD_STATUS = 6'h30;

    // Reset values.
    localparam logic [7:0] RST_FRAME_LIMIT = 8'h00;
    localparam logic [7:0] RST_PLL = 8'h02;
    localparam logic [7:0] RST_DISABLE = 8'hf0;
    localparam logic [7:0] RST_MODE = 8'h03;

    // Bits that hold state; the rest return their reset value.
    localparam logic [7:0] WMASK_PLL = 8'h0f;
    localparam logic [7:0] WMASK_DISABLE = 8'hf0;
    localparam logic [7:0] WMASK_MODE = 8'h4d;

    // Field positions.
    localparam int POS_OSC_SEL = 3;
    localparam int POS_HALF_REF = 2;
    localparam int POS_RATE = 0;
    localparam int POS_PORT_OFF = 4;
    localparam int POS_SEND_READY = 6;
    localparam int POS_SYNC_MODE = 2;
    localparam int POS_BEST_EFFORT = 0;
    localparam int POS_STS_BUSY = 0;
    localparam int POS_STS_WAIT = 1;

    typedef enum logic [1:0] {
        FWDC_SYNC_OFF = 2'b00,
        FWDC_SYNC_BASIC = 2'b01,
        FWDC_SYNC_INTERLEAVE = 2'b10,
        FWDC_SYNC_CONCAT = 2'b11
    } fwdc_sync_t;

    typedef enum logic [1:0] {
        FWDC_RATE_FAST = 2'b00,
        FWDC_RATE_1G2 = 2'b01,
        FWDC_RATE_800M = 2'b10,
        FWDC_RATE_400M = 2'b11
    } fwdc_rate_t;

    typedef enum logic [1:0] {
        FWDC_ST_IDLE = 2'b00,
        FWDC_ST_SEND = 2'b01
    } fwdc_state_t;

endpackage

// ---- design/fwdc_sync.sv ----
// Purpose: Two flip-flop synchronizer for levels entering a clock domain.
// Assumes: Each bit is a level that stays put for several destination cycles.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/10ps
module fwdc_sync #(
    parameter int W = 1
) (
    // Destination clock.
    input wire logic clk,
    // Level in and synchronized level out.
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_q;

    always_ff @(posedge clk) begin
        meta_q <= d;
        q <= meta_q;
    end

endmodule

// ---- design/fwdc_top.sv ----
// Purpose: Forwarding and clock configuration bank with the link-side forwarding engine.
// Assumes: Link inputs are produced by logic clocked on LINK_CLK.
// Notes: Configuration crosses as synchronized levels; change it while forwarding is idle.
`timescale 1ns/10ps
module fwdc_top (
    // System clock and reset.
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    // APB slave.
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [fwdc_pkg::ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Clock generation controls.
    output logic INTERNAL_OSC_SELECT,
    output logic REF_CLK_HALF_RATE,
    output logic [1:0] TX_LANE_RATE,
    // Link side, all on LINK_CLK.
    input wire logic LINK_CLK,
    input wire logic [fwdc_pkg::NUM_PORTS-1:0] LINE_READY,
    input wire logic [fwdc_pkg::NUM_PORTS-1:0] LINE_IS_LONG,
    input wire logic LINE_DONE,
    input wire logic FRAME_START,
    output logic [fwdc_pkg::NUM_PORTS-1:0] FWD_GRANT,
    output logic [fwdc_pkg::FRAME_W-1:0] FRAME_NUMBER
);

    localparam int CFG_W = fwdc_pkg::FRAME_W + fwdc_pkg::NUM_PORTS + 4;
    localparam logic [1:0] ALIGN_OK = 2'h0;
    // Link-side view of the configuration while the link logic is held in reset.
    localparam logic [CFG_W-1:0] CFG_RST = {fwdc_pkg::RST_FRAME_LIMIT,
        fwdc_pkg::RST_FRAME_LIMIT,
        fwdc_pkg::RST_DISABLE[fwdc_pkg::POS_PORT_OFF +: fwdc_pkg::NUM_PORTS],
        fwdc_pkg::RST_MODE[fwdc_pkg::POS_SEND_READY],
        fwdc_pkg::RST_MODE[fwdc_pkg::POS_SYNC_MODE +: 2],
        fwdc_pkg::RST_MODE[fwdc_pkg::POS_BEST_EFFORT]};

    // Register file state.
    logic [7:0] limit_high_q, limit_high_d;
    logic [7:0] limit_low_q, limit_low_d;
    logic [7:0] pll_q, pll_d;
    logic [7:0] disable_q, disable_d;
    logic [7:0] mode_q, mode_d;
    logic [31:0] prdata_q, prdata_d;
    logic pslverr_q, pslverr_d;

    // Crossing signals.
    logic [CFG_W-1:0] cfg_sys;
    logic [CFG_W-1:0] cfg_link;
    logic [1:0] sts_link;
    logic [1:0] sts_sys;
    logic [0:0] link_rst_n;

    logic [fwdc_pkg::IDX_W-1:0] idx;
    logic hit;
    logic [7:0] rd_byte;
    logic wr_en;

    assign idx = PADDR[fwdc_pkg::ADDR_W-1:2];
    assign wr_en = PSEL && PENABLE && PWRITE && PSTRB[0];

    // Zero wait states: data and error are captured during the setup cycle.
    assign PREADY = 1'b1;
    assign PRDATA = prdata_q;
    assign PSLVERR = pslverr_q;

    always_comb begin
        hit = 1'b1;
        rd_byte = 8'h00;
        if (PADDR[1:0] != ALIGN_OK) begin
            hit = 1'b0;
        end else if (idx == fwdc_pkg::IDX_FRAME_LIMIT_HIGH) begin
            rd_byte = limit_high_q;
        end else if (idx == fwdc_pkg::IDX_MAX_FRAME_COUNT_LOW) begin
            rd_byte = limit_low_q;
        end else if (idx == fwdc_pkg::IDX_CSI_PLL_CLOCK_CONTROL) begin
            rd_byte = pll_q;
        end else if (idx == fwdc_pkg::IDX_PORT_FORWARD_DISABLE) begin
            rd_byte = disable_q;
        end else if (idx == fwdc_pkg::IDX_FORWARD_MODE_CONTROL) begin
            rd_byte = mode_q;
        end else if (idx == fwdc_pkg::IDX_FORWARD_STATUS) begin
            rd_byte = {6'h00, sts_sys};
        end else begin
            hit = 1'b0;
        end
    end

    // Stored bits are merged with the reset value so reserved bits never change.
    always_comb begin
        limit_high_d = limit_high_q;
        limit_low_d = limit_low_q;
        pll_d = pll_q;
        disable_d = disable_q;
        mode_d = mode_q;
        prdata_d = prdata_q;
        pslverr_d = pslverr_q;
        if (PSEL && !PENABLE) begin
            prdata_d = {24'h000000, rd_byte};
            pslverr_d = !hit;
        end
        if (wr_en && hit) begin
            if (idx == fwdc_pkg::IDX_FRAME_LIMIT_HIGH) begin
                limit_high_d = PWDATA[7:0];
            end else if (idx == fwdc_pkg::IDX_MAX_FRAME_COUNT_LOW) begin
                limit_low_d = PWDATA[7:0];
            end else if (idx == fwdc_pkg::IDX_CSI_PLL_CLOCK_CONTROL) begin
                pll_d = (PWDATA[7:0] & fwdc_pkg::WMASK_PLL)
                    | (fwdc_pkg::RST_PLL & ~fwdc_pkg::WMASK_PLL);
            end else if (idx == fwdc_pkg::IDX_PORT_FORWARD_DISABLE) begin
                disable_d = (PWDATA[7:0] & fwdc_pkg::WMASK_DISABLE)
                    | (fwdc_pkg::RST_DISABLE & ~fwdc_pkg::WMASK_DISABLE);
            end else if (idx == fwdc_pkg::IDX_FORWARD_MODE_CONTROL) begin
                mode_d = (PWDATA[7:0] & fwdc_pkg::WMASK_MODE)
                    | (fwdc_pkg::RST_MODE & ~fwdc_pkg::WMASK_MODE);
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            limit_high_q <= fwdc_pkg::RST_FRAME_LIMIT;
            limit_low_q <= fwdc_pkg::RST_FRAME_LIMIT;
            pll_q <= fwdc_pkg::RST_PLL;
            disable_q <= fwdc_pkg::RST_DISABLE;
            mode_q <= fwdc_pkg::RST_MODE;
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else begin
            limit_high_q <= limit_high_d;
            limit_low_q <= limit_low_d;
            pll_q <= pll_d;
            disable_q <= disable_d;
            mode_q <= mode_d;
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    // Clock selection acts directly from the registers in the system domain.
    assign INTERNAL_OSC_SELECT = pll_q[fwdc_pkg::POS_OSC_SEL];
    assign REF_CLK_HALF_RATE = pll_q[fwdc_pkg::POS_HALF_REF];
    assign TX_LANE_RATE = pll_q[fwdc_pkg::POS_RATE +: 2];

    assign cfg_sys = {limit_high_q, limit_low_q,
        disable_q[fwdc_pkg::POS_PORT_OFF +: fwdc_pkg::NUM_PORTS],
        mode_q[fwdc_pkg::POS_SEND_READY],
        mode_q[fwdc_pkg::POS_SYNC_MODE +: 2],
        mode_q[fwdc_pkg::POS_BEST_EFFORT]};

    fwdc_sync #(.W(1)) u_link_rst (
        .clk(LINK_CLK),
        .d(RESET_N),
        .q(link_rst_n)
    );

    fwdc_sync #(.W(CFG_W)) u_cfg_sync (
        .clk(LINK_CLK),
        .d(cfg_sys),
        .q(cfg_link)
    );

    // Each bit crosses on its own, so a word caught while it changes can be part old and
    // part new for one link cycle. The engine only takes a word that two successive samples
    // agree on, which keeps it from acting on a frame limit or mode that nobody wrote.
    logic [CFG_W-1:0] cfg_prev_q, cfg_prev_d;
    logic [CFG_W-1:0] cfg_ok_q, cfg_ok_d;

    always_comb begin
        cfg_prev_d = cfg_link;
        cfg_ok_d = cfg_ok_q;
        if (cfg_link == cfg_prev_q) begin
            cfg_ok_d = cfg_link;
        end
    end

    always_ff @(posedge LINK_CLK) begin
        if (!link_rst_n[0]) begin
            cfg_prev_q <= CFG_RST;
            cfg_ok_q <= CFG_RST;
        end else begin
            cfg_prev_q <= cfg_prev_d;
            cfg_ok_q <= cfg_ok_d;
        end
    end

    fwdc_sync #(.W(2)) u_sts_sync (
        .clk(CLK_SYS),
        .d(sts_link),
        .q(sts_sys)
    );

    // Link domain.
    logic [fwdc_pkg::FRAME_W-1:0] limit_l;
    logic [fwdc_pkg::NUM_PORTS-1:0] port_off_l;
    logic send_ready_l;
    fwdc_pkg::fwdc_sync_t sync_mode_l;
    logic best_effort_l;

    assign limit_l = cfg_ok_q[CFG_W-1 -: fwdc_pkg::FRAME_W];
    assign port_off_l = cfg_ok_q[4 +: fwdc_pkg::NUM_PORTS];
    assign send_ready_l = cfg_ok_q[3];
    assign sync_mode_l = fwdc_pkg::fwdc_sync_t'(cfg_ok_q[2:1]);
    assign best_effort_l = cfg_ok_q[0];

    fwdc_pkg::fwdc_state_t state_q, state_d;
    logic [fwdc_pkg::NUM_PORTS-1:0] grant_q, grant_d;
    logic [fwdc_pkg::NUM_PORTS-1:0] pending_q, pending_d;
    logic [fwdc_pkg::PORT_IDX_W-1:0] last_q, last_d;
    logic [fwdc_pkg::FRAME_W-1:0] frame_q, frame_d;
    logic waiting_q, waiting_d;

    logic [fwdc_pkg::NUM_PORTS-1:0] enabled;
    logic [fwdc_pkg::NUM_PORTS-1:0] ready_en;
    logic [fwdc_pkg::NUM_PORTS-1:0] long_ready;
    logic all_ready;

    // Picks one candidate, searching upward from the port after the last one served.
    function automatic logic [fwdc_pkg::NUM_PORTS-1:0] rr_pick(
        input logic [fwdc_pkg::NUM_PORTS-1:0] cand,
        input logic [fwdc_pkg::PORT_IDX_W-1:0] last
    );
        logic [fwdc_pkg::NUM_PORTS-1:0] pick;
        logic [fwdc_pkg::PORT_IDX_W-1:0] p;
        pick = '0;
        for (int i = fwdc_pkg::NUM_PORTS; i >= 1; i--) begin
            p = last + fwdc_pkg::PORT_IDX_W'(i);
            if (cand[p]) begin
                pick = '0;
                pick[p] = 1'b1;
            end
        end
        return pick;
    endfunction

    function automatic logic [fwdc_pkg::PORT_IDX_W-1:0] onehot_idx(
        input logic [fwdc_pkg::NUM_PORTS-1:0] oh,
        input logic [fwdc_pkg::PORT_IDX_W-1:0] dflt
    );
        logic [fwdc_pkg::PORT_IDX_W-1:0] r;
        r = dflt;
        for (int i = 0; i < fwdc_pkg::NUM_PORTS; i++) begin
            if (oh[i]) begin
                r = fwdc_pkg::PORT_IDX_W'(i);
            end
        end
        return r;
    endfunction

    assign enabled = ~port_off_l;
    assign ready_en = LINE_READY & enabled;
    assign long_ready = ready_en & LINE_IS_LONG;
    assign all_ready = (enabled != '0) && (ready_en == enabled);

    // Frame numbering.
    always_comb begin
        frame_d = frame_q;
        if (limit_l == '0) begin
            frame_d = '0;
        end else if (FRAME_START) begin
            if (frame_q == '0 || frame_q >= limit_l) begin
                frame_d = fwdc_pkg::FRAME_W'(1);
            end else begin
                frame_d = frame_q + fwdc_pkg::FRAME_W'(1);
            end
        end
    end

    // Forwarding engine. Synchronized modes take precedence if both are set.
    always_comb begin
        state_d = state_q;
        grant_d = grant_q;
        pending_d = pending_q & enabled;
        last_d = last_q;
        waiting_d = 1'b0;
        case (state_q)
            fwdc_pkg::FWDC_ST_IDLE: begin
                grant_d = '0;
                if (sync_mode_l == fwdc_pkg::FWDC_SYNC_CONCAT) begin
                    // Every enabled port goes out together as one joined line.
                    if (all_ready) begin
                        grant_d = enabled;
                        state_d = fwdc_pkg::FWDC_ST_SEND;
                    end else begin
                        waiting_d = enabled != '0;
                    end
                end else if (sync_mode_l != fwdc_pkg::FWDC_SYNC_OFF) begin
                    if ((pending_q & ready_en) != '0) begin
                        if (sync_mode_l == fwdc_pkg::FWDC_SYNC_BASIC) begin
                            grant_d = rr_pick(pending_q & ready_en,
                                fwdc_pkg::PORT_IDX_W'(fwdc_pkg::NUM_PORTS - 1));
                        end else begin
                            grant_d = rr_pick(pending_q & ready_en, last_q);
                        end
                        state_d = fwdc_pkg::FWDC_ST_SEND;
                    end else if (send_ready_l && long_ready != '0) begin
                        grant_d = rr_pick(long_ready, last_q);
                        state_d = fwdc_pkg::FWDC_ST_SEND;
                    end else if (all_ready) begin
                        pending_d = enabled;
                    end else begin
                        waiting_d = enabled != '0;
                    end
                end else if (best_effort_l && ready_en != '0) begin
                    grant_d = rr_pick(ready_en, last_q);
                    state_d = fwdc_pkg::FWDC_ST_SEND;
                end
                last_d = onehot_idx(grant_d, last_q);
            end
            fwdc_pkg::FWDC_ST_SEND: begin
                if (LINE_DONE) begin
                    pending_d = pending_q & ~grant_q & enabled;
                    grant_d = '0;
                    state_d = fwdc_pkg::FWDC_ST_IDLE;
                end
            end
            default: begin
                grant_d = '0;
                state_d = fwdc_pkg::FWDC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge LINK_CLK) begin
        if (!link_rst_n[0]) begin
            state_q <= fwdc_pkg::FWDC_ST_IDLE;
            grant_q <= '0;
            pending_q <= '0;
            last_q <= fwdc_pkg::PORT_IDX_W'(fwdc_pkg::NUM_PORTS - 1);
            frame_q <= '0;
            waiting_q <= 1'b0;
        end else begin
            state_q <= state_d;
            grant_q <= grant_d;
            pending_q <= pending_d;
            last_q <= last_d;
            frame_q <= frame_d;
            waiting_q <= waiting_d;
        end
    end

    assign sts_link = {waiting_q, state_q == fwdc_pkg::FWDC_ST_SEND};
    assign FWD_GRANT = grant_q;
    assign FRAME_NUMBER = frame_q;

endmodule

// ---- bench/fwdc_sva.sv ----
// Purpose: Port checks for the forwarding and clock configuration bank.
// Assumes: Link signals are sampled on LINK_CLK.
// Notes: Link checks follow a local two-stage copy of the reset, as the link logic does.
`timescale 1ns/10ps
module fwdc_sva (
    // Clocks and reset.
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic LINK_CLK,
    // APB.
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    input wire logic [31:0] PRDATA,
    input wire logic PSLVERR,
    // Clock controls.
    input wire logic INTERNAL_OSC_SELECT,
    input wire logic REF_CLK_HALF_RATE,
    input wire logic [1:0] TX_LANE_RATE,
    // Link.
    input wire logic [3:0] LINE_READY,
    input wire logic LINE_DONE,
    input wire logic FRAME_START,
    input wire logic [3:0] FWD_GRANT,
    input wire logic [15:0] FRAME_NUMBER
);
    wire logic mapped = PADDR inside {8'h74, 8'h78, 8'h7c, 8'h80, 8'h84, 8'hc0};
    // Mirrors the link reset synchronizer so link checks start and stop with the link logic.
    logic [1:0] link_live_q = 2'b00;
    always @(posedge LINK_CLK) begin
        link_live_q <= {link_live_q[0], RESET_N};
    end
    sequence clk_wr;
        PSEL && !PENABLE && PADDR == 8'h7c ##1 PSEL && PENABLE && PWRITE && PSTRB[0];
    endsequence
    sequence grant_held;
        FWD_GRANT != 4'h0 && !LINE_DONE;
    endsequence
    a_rate_reset: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        $rose(RESET_N) |-> TX_LANE_RATE == 2'b10 && !INTERNAL_OSC_SELECT) else $error("reset");
    a_osc_write: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        clk_wr |=> INTERNAL_OSC_SELECT == $past(PWDATA[3])) else $error("osc select");
    a_half_write: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        clk_wr |=> REF_CLK_HALF_RATE == $past(PWDATA[2])) else $error("half rate");
    a_rate_write: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        clk_wr |=> TX_LANE_RATE == $past(PWDATA[1:0])) else $error("lane rate");
    a_unmapped_err: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        PSEL && !PENABLE && !mapped |=> PSLVERR && PRDATA == 32'h0) else $error("unmapped");
    a_grant_hold: assert property (@(posedge LINK_CLK) disable iff (!link_live_q[1])
        grant_held |=> $stable(FWD_GRANT)) else $error("grant moved");
    a_grant_drop: assert property (@(posedge LINK_CLK) disable iff (!link_live_q[1])
        FWD_GRANT != 4'h0 && LINE_DONE |=> FWD_GRANT == 4'h0) else $error("grant stuck");
    a_grant_ready: assert property (@(posedge LINK_CLK) disable iff (!link_live_q[1])
        grant_held |-> (LINE_READY & FWD_GRANT) == FWD_GRANT) else $error("idle port");
    a_frame_step: assert property (@(posedge LINK_CLK) disable iff (!link_live_q[1])
        FRAME_START |=> FRAME_NUMBER <= 16'h1 || FRAME_NUMBER == $past(FRAME_NUMBER) + 16'h1)
        else $error("frame step");
endmodule
bind fwdc_top fwdc_sva u_sva (.CLK_SYS, .RESET_N, .LINK_CLK, .PSEL, .PENABLE, .PWRITE,
    .PADDR, .PWDATA, .PSTRB, .PRDATA, .PSLVERR, .INTERNAL_OSC_SELECT, .REF_CLK_HALF_RATE,
    .TX_LANE_RATE, .LINE_READY, .LINE_DONE, .FRAME_START, .FWD_GRANT, .FRAME_NUMBER);

// ---- bench/fwdc_link_model.sv ----
// Purpose: Receive-side source of video lines for the forwarding engine.
// Assumes: Bench pulses add for one link cycle per new line.
// Notes: Hold sets how many cycles a granted transfer takes before it completes.
`timescale 1ns/10ps
module fwdc_link_model (
    // Link clock.
    input wire logic link_clk,
    // Commands.
    input wire logic [3:0] add,
    input wire logic [3:0] long_in,
    input wire logic [1:0] hold,
    // Link.
    input wire logic [3:0] grant,
    output logic [3:0] line_ready,
    output logic [3:0] line_is_long,
    output logic line_done
);
    logic [3:0] ready_q = 4'h0;
    logic [3:0] long_q = 4'h0;
    logic [1:0] cnt_q = 2'h0;
    logic tog_q = 1'b0;
    logic done_q = 1'b0;
    // A port with nothing waiting shows a kind bit that flips each cycle, never a stale one.
    assign line_ready = ready_q;
    assign line_is_long = (ready_q & long_q) | (~ready_q & {4{tog_q}});
    assign line_done = done_q;
    always @(posedge link_clk) begin
        tog_q <= ~tog_q;
        long_q <= (long_q & ~add) | (long_in & add);
        if (done_q) begin
            done_q <= 1'b0;
            cnt_q <= 2'h0;
            ready_q <= ready_q | add;
        end else if (grant != 4'h0 && cnt_q == hold) begin
            done_q <= 1'b1;
            ready_q <= (ready_q | add) & ~grant;
        end else begin
            ready_q <= ready_q | add;
            if (grant != 4'h0)
                cnt_q <= cnt_q + 2'h1;
        end
    end
endmodule

// ---- bench/fwdc_top_tb_top.sv ----
// Purpose: Register and forwarding tests for the configuration bank.
// Assumes: Zero-wait APB slave; link clock runs free, unrelated to the system clock.
// Notes: Reset is held two cycles; the link side then waits out its own reset.
`timescale 1ns/10ps
module fwdc_top_tb_top;
    logic clk_sys = 1'b0;
    logic link_clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic frame_start = 1'b0;
    logic [3:0] add_q = 4'h0, long_q = 4'h0, prev_g = 4'h0;
    logic [1:0] hold_q = 2'h0;
    logic [31:0] prdata, rdata;
    logic pready, pslverr, osc, half, err, line_done;
    logic [1:0] rate;
    logic [3:0] line_ready, line_is_long, grant;
    logic [15:0] frame_no;
    logic [3:0] gq[$];
    logic [7:0] v;
    int failures = 0;
    int total_checks = 0;
    int i;

    always #20 clk_sys = ~clk_sys;
    always #15 link_clk = ~link_clk;

    fwdc_top dut (.CLK_SYS(clk_sys), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .INTERNAL_OSC_SELECT(osc),
        .REF_CLK_HALF_RATE(half), .TX_LANE_RATE(rate), .LINK_CLK(link_clk),
        .LINE_READY(line_ready), .LINE_IS_LONG(line_is_long), .LINE_DONE(line_done),
        .FRAME_START(frame_start), .FWD_GRANT(grant), .FRAME_NUMBER(frame_no));
    fwdc_link_model src (.link_clk(link_clk), .add(add_q), .long_in(long_q), .hold(hold_q),
        .grant(grant), .line_ready(line_ready), .line_is_long(line_is_long),
        .line_done(line_done));

    always @(posedge link_clk) begin
        if (grant !== 4'h0 && prev_g === 4'h0)
            gq.push_back(grant);
        prev_g <= grant;
    end

    task conclude();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            failures++;
            conclude();
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d}, 4'hf);
    endtask

    task rdc(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0, 4'hf);
        chk("read data", rdata, {24'h0, e});
        chk("read error", {31'h0, err}, 32'h0);
    endtask

    // Waits out the crossing of any new configuration before offering lines.
    task add(input logic [3:0] p, input logic [3:0] l);
        repeat (4) @(posedge link_clk);
        add_q <= p;
        long_q <= l;
        @(posedge link_clk);
        add_q <= 4'h0;
    endtask

    task grants(input int n, input logic [15:0] exp);
        logic [15:0] s;
        int k;
        s = 16'h0;
        for (k = 0; k < 40; k++) begin
            @(posedge link_clk);
            if (n > 0 && gq.size() >= n && grant === 4'h0)
                break;
        end
        foreach (gq[j])
            s = {s[11:0], gq[j]};
        chk("grant count", gq.size(), n);
        chk("grant order", {16'h0, s}, {16'h0, exp});
        gq.delete();
        if (n > 0 && k == 40) begin
            failures++;
            conclude();
        end
    endtask

    task fs(input logic [15:0] e);
        repeat (4) @(posedge link_clk);
        frame_start <= 1'b1;
        @(posedge link_clk);
        frame_start <= 1'b0;
        repeat (2) @(posedge link_clk);
        chk("frame number", {16'h0, frame_no}, {16'h0, e});
    endtask

    initial begin
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge link_clk);
        chk("clock pins", {osc, half, rate}, 4'h2);
        rdc(8'h78, 8'h00);
        rdc(8'h7c, 8'h02);
        rdc(8'h80, 8'hf0);
        rdc(8'h84, 8'h03);
        apb(1'b0, 8'h88, 32'h0, 4'hf);
        chk("unmapped", {err, rdata[30:0]}, 32'h80000000);
        for (i = 0; i < 4; i++) begin
            // Half rate stays off at the slowest lane rate.
            v = {4'hf, i[0], (i != 3), i[1:0]};
            wr(8'h7c, v);
            rdc(8'h7c, {4'h0, v[3:0]});
            chk("clock pins", {osc, half, rate}, v[3:0]);
        end
        apb(1'b1, 8'h7c, 32'hff, 4'h0);
        rdc(8'h7c, 8'h0b);
        wr(8'h80, 8'ha3);
        rdc(8'h80, 8'ha0);
        wr(8'h84, 8'hb3);
        rdc(8'h84, 8'h03);
        add(4'h4, 4'h4);
        grants(1, 16'h0004);
        hold_q <= 2'h3;
        add(4'hf, 4'hf);
        grants(2, 16'h0014);
        wr(8'h84, 8'h04);
        add(4'h1, 4'h1);
        grants(0, 16'h0);
        rdc(8'hc0, 8'h02);
        add(4'h4, 4'h4);
        grants(2, 16'h0014);
        wr(8'h84, 8'h08);
        add(4'h5, 4'h5);
        grants(2, 16'h0014);
        wr(8'h84, 8'h44);
        add(4'h4, 4'h4);
        grants(1, 16'h0004);
        add(4'h1, 4'h0);
        grants(0, 16'h0);
        wr(8'h84, 8'h4c);
        add(4'h4, 4'h4);
        grants(1, 16'h0005);
        wr(8'h84, 8'h00);
        add(4'h1, 4'h1);
        grants(0, 16'h0);
        wr(8'h84, 8'h01);
        grants(1, 16'h0001);
        fs(16'h0);
        wr(8'h78, 8'h03);
        for (i = 1; i < 5; i++)
            fs((i == 4) ? 16'h1 : i[15:0]);
        wr(8'h74, 8'h01);
        wr(8'h78, 8'h00);
        rdc(8'h74, 8'h01);
        fs(16'h2);
        conclude();
    end
endmodule
